// ===== shbp_pkg.sv
// shbp_pkg.sv: constants and carrier types for the synchronous host bus slave port
//
// Overview of operation
// - every bus signal launched and sampled on the one host reference clock.
// - host interface logic runs on device_clock_in, same domain as the bus.
// - no wait signal; every access completes in fixed cycle count.
// - port drives data only in a read, until the clock after the read strobe drops.
// - straps sampled at reset release select bus type; pins then take roles.
// - memory/register select (address bit 17) routes access to registers or memory.
// - address 16..0 and data 15..0 connect one-to-one without glue logic.
// - high/low byte write enables steer individual bytes on writes.
// - strap value 101 on low three pins selects this native bus.
// - registers in first 128 KB block, display buffer in second.
package shbp_pkg;

  localparam int          ADDR_W        = 17;
  localparam int          DATA_W        = 16;
  localparam int          STRAP_W       = 3;
  localparam logic [2:0]  BUS_TYPE_NATIVE = 3'h5;
  localparam logic        ENDIAN_BIG    = 1'b1;
  // fixed access length in clocks from sampled strobe to data/commit
  localparam int          ACCESS_CYC    = 2;
  localparam logic [1:0]  ACC_CNT_LAST  = 2'(ACCESS_CYC - 1);
  localparam logic [1:0]  ACC_CNT_ZERO  = 2'h0;
  localparam logic [15:0] DATA_ZERO     = 16'h0000;

  typedef struct packed {
    logic              cs_n;
    logic              mem_reg_sel;
    logic              rd_wr;
    logic              rd_n;
    logic              high_byte_write_n;
    logic              low_byte_write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } shbp_req_t;

  typedef struct packed {
    logic              mem_sel;
    logic              wr;
    logic [1:0]        byte_en;
    logic [ADDR_W-2:0] word_addr;
    logic [DATA_W-1:0] wdata;
  } shbp_acc_t;

endpackage

// ===== shbp_host_port.sv
// shbp_host_port.sv: synchronous 16-bit host bus slave port, no wait handshake
`timescale 1ns/1ps
module shbp_host_port (
  // clock and reset
  input  wire logic                         device_clock_in,
  input  wire logic                         rst_n,
  // configuration straps
  input  wire logic [shbp_pkg::STRAP_W-1:0] bus_type_strap,
  input  wire logic                         endian_strap,
  // host bus
  input  wire shbp_pkg::shbp_req_t          bus_req,
  input  wire logic                         bus_start_n,
  output logic [shbp_pkg::DATA_W-1:0]       device_data_out,
  output logic                              device_data_oe,
  // internal access side
  output shbp_pkg::shbp_acc_t               acc_out,
  output logic                              acc_valid,
  input  wire logic [shbp_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [shbp_pkg::DATA_W-1:0]  mem_rdata,
  output logic                              port_enabled,
  output logic                              big_endian
);
  import shbp_pkg::*;

  typedef enum logic [2:0] {
    SHBP_IDLE = 3'b001,
    SHBP_BUSY = 3'b010,
    SHBP_HOLD = 3'b100
  } shbp_state_t;

  function automatic logic [1:0] shbp_bytes(input shbp_req_t r);
    return {~r.high_byte_write_n, ~r.low_byte_write_n};
  endfunction

  shbp_state_t     state_q;
  logic [1:0]      cnt_q;
  logic            rst_seen_q;
  shbp_acc_t       acc_q;
  logic            rd_q;
  logic            start;
  logic            rd_live;

  // -----------------------------------------------------------------
  // strap capture
  // -----------------------------------------------------------------
  // straps caught on the first clock after reset release, not in reset
  always_ff @(posedge device_clock_in) begin
    if (!rst_n) begin
      rst_seen_q   <= 1'b0;
      port_enabled <= 1'b0;
      big_endian   <= 1'b0;
    end else if (!rst_seen_q) begin
      rst_seen_q   <= 1'b1;
      port_enabled <= (bus_type_strap == BUS_TYPE_NATIVE);
      big_endian   <= (endian_strap == ENDIAN_BIG);
    end
  end

  // -----------------------------------------------------------------
  // access sequencing
  // -----------------------------------------------------------------
  // bus_start_n is unused in this mode; access starts on strobes only
  assign start   = port_enabled && !bus_req.cs_n &&
                   (!bus_req.rd_wr ? (shbp_bytes(bus_req) != 2'b00)
                                   : !bus_req.rd_n);
  assign rd_live = !bus_req.cs_n && bus_req.rd_wr && !bus_req.rd_n;

  always_ff @(posedge device_clock_in) begin
    if (!rst_n) begin
      state_q <= SHBP_IDLE;
      cnt_q   <= ACC_CNT_ZERO;
      acc_q   <= '0;
      rd_q    <= 1'b0;
    end else begin
      case (state_q)
        SHBP_IDLE: begin
          if (start) begin
            state_q         <= SHBP_BUSY;
            cnt_q           <= ACC_CNT_ZERO;
            rd_q            <= bus_req.rd_wr;
            acc_q.mem_sel   <= bus_req.mem_reg_sel;
            acc_q.wr        <= !bus_req.rd_wr;
            acc_q.byte_en   <= shbp_bytes(bus_req);
            acc_q.word_addr <= bus_req.addr[ADDR_W-1:1];
            acc_q.wdata     <= bus_req.wdata;
          end
        end
        SHBP_BUSY: begin
          if (cnt_q == ACC_CNT_LAST) begin
            state_q <= SHBP_HOLD;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        SHBP_HOLD: begin
          // wait for the host to end the cycle before taking another
          if (bus_req.cs_n || (rd_q ? bus_req.rd_n
                                    : (shbp_bytes(bus_req) == 2'b00))) begin
            state_q <= SHBP_IDLE;
          end
        end
        default: state_q <= SHBP_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_ff @(posedge device_clock_in) begin
    if (!rst_n) begin
      acc_valid <= 1'b0;
      acc_out   <= '0;
    end else begin
      acc_valid <= (state_q == SHBP_IDLE) && start;
      if ((state_q == SHBP_IDLE) && start) begin
        acc_out.mem_sel   <= bus_req.mem_reg_sel;
        acc_out.wr        <= !bus_req.rd_wr;
        acc_out.byte_en   <= shbp_bytes(bus_req);
        acc_out.word_addr <= bus_req.addr[ADDR_W-1:1];
        acc_out.wdata     <= bus_req.wdata;
      end
    end
  end

  // read data held until the strobe drops; released the cycle after
  always_ff @(posedge device_clock_in) begin
    if (!rst_n) begin
      device_data_out <= DATA_ZERO;
      device_data_oe  <= 1'b0;
    end else begin
      device_data_oe <= rd_q && rd_live && (state_q == SHBP_HOLD)
                        && (bus_req.addr[ADDR_W-1:1] == acc_q.word_addr);
      if (state_q == SHBP_BUSY && rd_q && cnt_q == ACC_CNT_LAST) begin
        device_data_out <= acc_q.mem_sel ? mem_rdata : reg_rdata;
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  sequence s_rd_issue;
    (state_q == SHBP_IDLE) && start && bus_req.rd_wr;
  endsequence

  AST_NO_DRIVE_ON_WRITE: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    device_data_oe |-> $past(bus_req.rd_wr) && !$past(bus_req.rd_n))
    else $error("data driven outside a read strobe");
  AST_CS_IGNORE: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    (state_q == SHBP_IDLE) && bus_req.cs_n |=> !acc_valid)
    else $error("access taken with chip select high");
  AST_FIXED_LEN: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    (state_q == SHBP_IDLE) && start |=> (state_q == SHBP_BUSY) [*2] ##1 (state_q == SHBP_HOLD))
    else $error("access length not fixed");
  AST_RD_DATA: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    s_rd_issue ##1 1'b1 ##1 (state_q == SHBP_BUSY) |=>
      device_data_out == (acc_q.mem_sel ? $past(mem_rdata) : $past(reg_rdata)))
    else $error("read data from wrong block");
  AST_BYTE_EN: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    (state_q == SHBP_IDLE) && start && !bus_req.rd_wr |=>
      acc_out.wr && acc_out.byte_en == {~$past(bus_req.high_byte_write_n),
                                        ~$past(bus_req.low_byte_write_n)})
    else $error("write byte enables mis-steered");
  AST_STRAP: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    $rose(rst_seen_q) |-> port_enabled == ($past(bus_type_strap) == BUS_TYPE_NATIVE))
    else $error("bus type strap decoded wrongly");
  AST_DISABLED: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    !port_enabled |=> !acc_valid)
    else $error("access taken with port not selected");
  AST_VALID_PULSE: assert property (@(posedge device_clock_in) disable iff (!rst_n)
    acc_valid |=> !acc_valid ##0 (acc_out.wr == !rd_q))
    else $error("access pulse or direction wrong");

endmodule

// ===== shbp_proc_model.sv
// shbp_proc_model.sv: processor-side bus master model for the host port
`timescale 1ns/1ps
module shbp_proc_model (
  // bus clock
  input  wire logic           clk,
  // bus request
  output shbp_pkg::shbp_req_t bus_req
);
  import shbp_pkg::*;
  // ---------------------------------------------
  // launch just after an edge, hold whole until stop
  // ---------------------------------------------
  task automatic start(input shbp_req_t r);
    @(posedge clk);
    #1;
    bus_req = r;
  endtask
  // released strobes go inactive; address and data lines show the inverse so stale values never pass
  task automatic stop();
    @(posedge clk);
    #1;
    bus_req = {6'h2F, ~bus_req.addr, ~bus_req.wdata};
  endtask
  initial bus_req = {6'h2F, 17'h00000, 16'h0000};
endmodule

// ===== shbp_host_port_bench.sv
// shbp_host_port_bench.sv: self-checking bench for the host bus slave port
`timescale 1ns/1ps
module shbp_host_port_bench;
  import shbp_pkg::*;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic [2:0]  strap  = 3'h4;
  logic        endian = 1'b0;
  logic [15:0] reg_rd = 16'hA5C3;
  logic [15:0] mem_rd = 16'h3C5A;
  shbp_req_t   req;
  shbp_acc_t   acc;
  logic [15:0] dout;
  logic        oe, vld, en, big;
  int          n_fail = 0;
  int          tests_run = 0;
  always #2 clk = ~clk;
  shbp_proc_model shbp_proc_model_inst (.clk(clk), .bus_req(req));
  // bus start tied high as the board does
  shbp_host_port shbp_host_port_inst (.device_clock_in(clk), .rst_n(rst_n),
    .bus_type_strap(strap), .endian_strap(endian), .bus_req(req), .bus_start_n(1'b1),
    .device_data_out(dout), .device_data_oe(oe), .acc_out(acc), .acc_valid(vld),
    .reg_rdata(reg_rd), .mem_rdata(mem_rd), .port_enabled(en), .big_endian(big));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] s);
    strap = s;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic shbp_req_t mk(input logic rd, input logic mem, input logic [16:0] a,
                                   input logic [1:0] ben_n, input logic [15:0] d);
    return {1'b0, mem, rd, ~rd, ben_n, a, d};
  endfunction
  task automatic access(input shbp_req_t r, input logic ok);
    logic rd;
    rd = ok && r.rd_wr;
    shbp_proc_model_inst.start(r);
    @(posedge clk);
    #1;
    chk("acc_valid", {31'h0, ok}, {31'h0, vld});
    if (ok) begin
      chk("acc_wr", {31'h0, ~r.rd_wr}, {31'h0, acc.wr});
      chk("acc_mem", {31'h0, r.mem_reg_sel}, {31'h0, acc.mem_sel});
      chk("acc_addr", {16'h0, r.addr[16:1]}, {16'h0, acc.word_addr});
    end
    if (ok && !r.rd_wr) begin
      chk("acc_be", {30'h0, ~r.high_byte_write_n, ~r.low_byte_write_n},
          {30'h0, acc.byte_en});
      chk("acc_wdata", {16'h0, r.wdata}, {16'h0, acc.wdata});
    end
    chk("oe_early", 32'h0, {31'h0, oe});
    repeat (4) @(posedge clk);
    #1;
    chk("oe", {31'h0, rd}, {31'h0, oe});
    if (rd) begin
      chk("rdata", {16'h0, r.mem_reg_sel ? mem_rd : reg_rd}, {16'h0, dout});
    end
    shbp_proc_model_inst.stop();
    repeat (2) @(posedge clk);
    #1;
    chk("oe_off", 32'h0, {31'h0, oe});
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic strap_scn();
    do_reset(3'h4);
    chk("port_enabled", 32'h0, {31'h0, en});
    chk("big_endian", 32'h0, {31'h0, big});
    access(mk(1'b1, 1'b0, 17'h00010, 2'h0, 16'h0000), 1'b0);
    endian = 1'b1;
    do_reset(3'h5);
    chk("port_enabled", 32'h1, {31'h0, en});
    chk("big_endian", 32'h1, {31'h0, big});
  endtask
  task automatic read_scn();
    shbp_req_t r;
    access(mk(1'b1, 1'b0, 17'h1FFFE, 2'h0, 16'h0000), 1'b1);
    reg_rd = 16'h5A3C;
    access(mk(1'b1, 1'b1, 17'h00002, 2'h0, 16'h0000), 1'b1);
    r = mk(1'b1, 1'b0, 17'h00004, 2'h0, 16'h0000);
    r.cs_n = 1'b1;
    access(r, 1'b0);
  endtask
  task automatic write_scn();
    shbp_req_t r;
    // last pass: a full write with the read strobe low must stay a write
    for (int i = 0; i < 5; i++) begin
      r = mk(1'b0, i[0], 17'h0AAA0 + 17'(i * 2), 2'(i), 16'hC3A5 ^ 16'(i));
      r.rd_n = (i >= 3) ? 1'b0 : 1'b1;
      access(r, i != 3);
    end
  endtask
  initial begin
    strap_scn();
    read_scn();
    write_scn();
    report_and_stop();
  end
  // whole run needs about 105 cycles
  initial begin
    repeat (400) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule
